// >>> rtl/tcp_defs.svh
// Constants for one 16-bit timer half: register offsets, field positions, reset values and codes.
// Assumes inclusion by its bare name from the package and the timer module.
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// ==========================================
// Register byte offsets
`define TCP_OFS_CFG 12'h000
`define TCP_OFS_MODE 12'h004
`define TCP_OFS_CTL 12'h00C
`define TCP_OFS_IMR 12'h018
`define TCP_OFS_RIS 12'h01C
`define TCP_OFS_MIS 12'h020
`define TCP_OFS_ICR 12'h024
`define TCP_OFS_ILR 12'h028
`define TCP_OFS_MATCH 12'h030
`define TCP_OFS_PR 12'h038
`define TCP_OFS_TV 12'h048

// ==========================================
// Field widths, flag positions and codes
`define TCP_CFG_W 3
`define TCP_MODE_W 4
`define TCP_CTL_W 6
`define TCP_FLG_W 3
`define TCP_FLG_TO 0
`define TCP_FLG_MATCH 1
`define TCP_FLG_CAP 2
`define TCP_CFG_16BIT 3'h4
`define TCP_TMR_ONESHOT 2'h1
`define TCP_TMR_PERIODIC 2'h2
`define TCP_TMR_CAPTURE 2'h3
`define TCP_EDGE_RISE 2'h0
`define TCP_EDGE_FALL 2'h1
`define TCP_EDGE_BOTH 2'h3

// ==========================================
// Reset values
`define TCP_CNT_RST 16'hFFFF
`define TCP_ILR_RST 16'hFFFF
`define TCP_PRE_RST 8'h00

`endif

// >>> rtl/tcp_pkg.sv
// Types shared by the timer half: mode and control layouts and the decoded operating mode.
// Assumes tcp_defs.svh is on the include path.
`default_nettype none
`include "tcp_defs.svh"

package tcp_pkg;
    // ==========================================
    // Register layouts
    typedef struct packed {
        logic alt_mode;
        logic capture_kind_bit;
        logic [1:0] timer_mode_field;
    } tcp_mode_s;

    typedef struct packed {
        logic pwm_invert_bit;
        logic output_trigger_enable;
        logic [1:0] edge_type_select;
        logic count_freeze_enable;
        logic timer_enable_bit;
    } tcp_ctl_s;

    // ==========================================
    // Decoded operating mode
    typedef enum logic [2:0] {
        TCP_IDLE,
        TCP_ONESHOT,
        TCP_PERIODIC,
        TCP_ECOUNT,
        TCP_ETIME,
        TCP_PWM
    } tcp_op_e;
endpackage

`default_nettype wire

// >>> rtl/tcp_timer16.sv
// One 16-bit timer half: one-shot, periodic, edge count, edge time and PWM, behind an APB slave.
// Assumes an APB master on pclk; the capture pin may be asynchronous to pclk.
//
// Contract
// - Reaching zero in one-shot or periodic sets timeout raw flag until cleared.
// - Unmasked timeout raw flag also shows masked and drives the interrupt line.
// - Timeout trigger pulse leaves only while output trigger enable is set.
// - Writing interval load reloads the counter on the next clock.
// - Freeze bit holds the counter until it is cleared.
// - Prescale p makes each decrement take p+1 clocks.
// - Edge count, edge time and PWM modes bypass the prescaler.
// - Capture kind zero counts rising, falling or both edges down.
// - Each event decrements; reaching match sets match raw flag, and masked flag if unmasked.
// - After match, reload, clear enable, ignore events until re-enabled.
// - Capture kind one runs free from interval load, single edge type.
// - Selected edge copies count to timer value and sets capture flags.
// - Edge time counter keeps running and reloads from interval at zero.
// - Captured count stays until the next selected edge overwrites it.
// - PWM only with alternate mode one, capture kind zero, mode two.
// - PWM counts down, reloads after zero, raises no flags.
// - PWM goes active at interval load value, inactive at match value.
// - Invert bit drives the inverse PWM waveform on the pin.
// - Zero reloads interval and prescale; one-shot clears enable, periodic continues.
// - The half runs only when global configuration selects 16-bit mode.
// - Mode field one is one-shot, two is periodic.
// - Mode field three selects capture, kind bit picks count or time.
//
// The implementer's own choices: register access over APB and the address map.
`default_nettype none
`include "tcp_defs.svh"

module tcp_timer16 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic timeout_trigger,
    input wire logic capture_compare_pin_in,
    output logic capture_compare_pin_out,
    output logic capture_compare_pin_oe_n
);
    import tcp_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================
    // Registers
    logic [`TCP_CFG_W-1:0] cfg_r;
    tcp_mode_s mode_r;
    tcp_ctl_s ctl_r;
    logic [`TCP_FLG_W-1:0] imr_r, ris_r;
    logic [15:0] ilr_r, match_r, cnt_r, cap_r;
    logic [7:0] pr_r, pre_cnt_r;
    logic pwm_r, pin_s1_r, pin_s2_r, pin_s3_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r, irq_r, trig_r, pin_out_r, pin_oe_n_r;

    // Next values
    logic [15:0] cnt_nxt, cap_nxt;
    logic [7:0] pre_nxt;
    logic pwm_nxt, hw_en_clr;
    logic [`TCP_FLG_W-1:0] set_vec, ris_nxt;

    // ==========================================
    // APB decode
    wire setup_w = psel & ~penable;
    wire wr_w = psel & penable & pready_r & pwrite;
    wire hit_cfg = paddr == `TCP_OFS_CFG;
    wire hit_mode = paddr == `TCP_OFS_MODE;
    wire hit_ctl = paddr == `TCP_OFS_CTL;
    wire hit_imr = paddr == `TCP_OFS_IMR;
    wire hit_ris = paddr == `TCP_OFS_RIS;
    wire hit_mis = paddr == `TCP_OFS_MIS;
    wire hit_icr = paddr == `TCP_OFS_ICR;
    wire hit_ilr = paddr == `TCP_OFS_ILR;
    wire hit_match = paddr == `TCP_OFS_MATCH;
    wire hit_pr = paddr == `TCP_OFS_PR;
    wire hit_tv = paddr == `TCP_OFS_TV;
    wire hit_any = hit_cfg | hit_mode | hit_ctl | hit_imr | hit_ris | hit_mis | hit_icr | hit_ilr
                   | hit_match | hit_pr | hit_tv;
    wire ilr_wr = wr_w & hit_ilr;
    wire [`TCP_FLG_W-1:0] clr_vec = (wr_w & hit_icr) ? pwdata[`TCP_FLG_W-1:0] : '0;
    wire [`TCP_FLG_W-1:0] mis_w = ris_r & imr_r;

    // ==========================================
    // Mode decode
    // gate on 16-bit configuration
    wire active16 = cfg_r == `TCP_CFG_16BIT;
    wire is_cap = ~mode_r.alt_mode & (mode_r.timer_mode_field == `TCP_TMR_CAPTURE);
    wire is_pwm = mode_r.alt_mode & ~mode_r.capture_kind_bit & (mode_r.timer_mode_field == `TCP_TMR_PERIODIC);
    wire is_os = ~mode_r.alt_mode & (mode_r.timer_mode_field == `TCP_TMR_ONESHOT);
    wire is_per = ~mode_r.alt_mode & (mode_r.timer_mode_field == `TCP_TMR_PERIODIC);
    // capture kind picks count or time
    tcp_op_e mode_w;
    assign mode_w = !active16 ? TCP_IDLE :
                    is_pwm ? TCP_PWM :
                    (is_cap & mode_r.capture_kind_bit) ? TCP_ETIME :
                    is_cap ? TCP_ECOUNT :
                    is_os ? TCP_ONESHOT :
                    is_per ? TCP_PERIODIC : TCP_IDLE;
    wire run_w = ctl_r.timer_enable_bit & ~ctl_r.count_freeze_enable;

    // ==========================================
    // Pin edge detection on the synchronised level
    wire rise_w = pin_s2_r & ~pin_s3_r;
    wire fall_w = ~pin_s2_r & pin_s3_r;
    wire [1:0] esel = ctl_r.edge_type_select;
    wire ev_count = ((esel == `TCP_EDGE_RISE) & rise_w) | ((esel == `TCP_EDGE_FALL) & fall_w)
                    | ((esel == `TCP_EDGE_BOTH) & (rise_w | fall_w));
    // edge time takes one edge type only
    wire ev_time = (esel == `TCP_EDGE_FALL) ? fall_w : rise_w;
    wire [15:0] cnt_dec = cnt_r - 16'h0001;
    wire cnt_zero = cnt_r == 16'h0000;

    // ==========================================
    // Counter, prescaler, capture and PWM next state
    always_comb
    begin
        cnt_nxt = cnt_r;
        pre_nxt = pre_cnt_r;
        cap_nxt = cap_r;
        pwm_nxt = pwm_r;
        hw_en_clr = 1'b0;
        set_vec = '0;
        // new interval load taken at once
        if (ilr_wr) cnt_nxt = pwdata[15:0];
        else if (run_w)
        begin
            case (mode_w)
                TCP_ONESHOT, TCP_PERIODIC:
                begin
                    if (pre_cnt_r != 8'h00) pre_nxt = pre_cnt_r - 8'h01;
                    else
                    begin
                        pre_nxt = pr_r;
                        if (cnt_zero)
                        begin
                            cnt_nxt = ilr_r;
                            set_vec[`TCP_FLG_TO] = 1'b1;
                            hw_en_clr = mode_w == TCP_ONESHOT;
                        end
                        else cnt_nxt = cnt_dec;
                    end
                end
                TCP_ECOUNT:
                begin
                    // one step per event, no prescaler
                    if (ev_count)
                    begin
                        if (cnt_dec == match_r)
                        begin
                            cnt_nxt = ilr_r;
                            set_vec[`TCP_FLG_MATCH] = 1'b1;
                            hw_en_clr = 1'b1;
                        end
                        else cnt_nxt = cnt_dec;
                    end
                end
                TCP_ETIME:
                begin
                    cnt_nxt = cnt_zero ? ilr_r : cnt_dec;
                    if (ev_time)
                    begin
                        cap_nxt = cnt_r;
                        set_vec[`TCP_FLG_CAP] = 1'b1;
                    end
                end
                TCP_PWM:
                begin
                    cnt_nxt = cnt_zero ? ilr_r : cnt_dec;
                    // set at load, clear at match
                    if (cnt_r == ilr_r) pwm_nxt = 1'b1;
                    else if (cnt_r == match_r) pwm_nxt = 1'b0;
                end
                default: cnt_nxt = cnt_r;
            endcase
        end
    end

    // flag held until cleared, set wins
    // clear only where a one is written
    assign ris_nxt = (ris_r & ~clr_vec) | set_vec;

    // ==========================================
    // Pin synchroniser
    // two flops before any edge logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) {pin_s3_r, pin_s2_r, pin_s1_r} <= 3'h0;
        else {pin_s3_r, pin_s2_r, pin_s1_r} <= {pin_s2_r, pin_s1_r, capture_compare_pin_in};
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r <= '0;
            mode_r <= '0;
            ctl_r <= '0;
            imr_r <= '0;
            ilr_r <= `TCP_ILR_RST;
            match_r <= '0;
            pr_r <= `TCP_PRE_RST;
        end
        else
        begin
            if (wr_w & hit_cfg) cfg_r <= pwdata[`TCP_CFG_W-1:0];
            if (wr_w & hit_mode) mode_r <= tcp_mode_s'(pwdata[`TCP_MODE_W-1:0]);
            if (wr_w & hit_imr) imr_r <= pwdata[`TCP_FLG_W-1:0];
            if (ilr_wr) ilr_r <= pwdata[15:0];
            if (wr_w & hit_match) match_r <= pwdata[15:0];
            if (wr_w & hit_pr) pr_r <= pwdata[7:0];
            // Software write wins over the hardware enable clear
            if (wr_w & hit_ctl) ctl_r <= tcp_ctl_s'(pwdata[`TCP_CTL_W-1:0]);
            else if (hw_en_clr) ctl_r.timer_enable_bit <= 1'b0;
        end
    end

    // Counting state and flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= `TCP_CNT_RST;
            pre_cnt_r <= `TCP_PRE_RST;
            cap_r <= '0;
            pwm_r <= 1'b0;
            ris_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            pre_cnt_r <= pre_nxt;
            cap_r <= cap_nxt;
            pwm_r <= pwm_nxt;
            ris_r <= ris_nxt;
        end
    end

    // ==========================================
    // Outputs, all from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_r <= 1'b0;
            trig_r <= 1'b0;
            pin_out_r <= 1'b0;
            pin_oe_n_r <= 1'b1;
        end
        else
        begin
            irq_r <= |(ris_nxt & imr_r);
            trig_r <= set_vec[`TCP_FLG_TO] & ctl_r.output_trigger_enable;
            pin_out_r <= pwm_r ^ ctl_r.pwm_invert_bit;
            pin_oe_n_r <= mode_w != TCP_PWM;
        end
    end

    // Read data selection, zero for unmapped offsets
    wire [31:0] rd_mux = hit_cfg ? {29'h0, cfg_r} :
                         hit_mode ? {28'h0, mode_r} :
                         hit_ctl ? {26'h0, ctl_r} :
                         hit_imr ? {29'h0, imr_r} :
                         hit_ris ? {29'h0, ris_r} :
                         hit_mis ? {29'h0, mis_w} :
                         hit_ilr ? {16'h0, ilr_r} :
                         hit_match ? {16'h0, match_r} :
                         hit_pr ? {24'h0, pr_r} :
                         hit_tv ? {16'h0, (mode_w == TCP_ETIME) ? cap_r : cnt_r} : 32'h0;

    // APB answer: data latched in setup, ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup_w;
            pslverr_r <= setup_w & ~hit_any;
            if (setup_w) prdata_r <= rd_mux;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign timeout_trigger = trig_r;
    assign capture_compare_pin_out = pin_out_r;
    assign capture_compare_pin_oe_n = pin_oe_n_r;

    // ==========================================
    // Assertions
    a_timeout_hold: assert property (ris_r[`TCP_FLG_TO] && !clr_vec[`TCP_FLG_TO] |=> ris_r[`TCP_FLG_TO])
        else $error("timeout flag dropped without clear");
    a_irq_masked: assert property (##1 irq_r == |$past(ris_nxt & imr_r))
        else $error("interrupt line not masked flags");
    a_trigger_gate: assert property (trig_r |-> $past(ctl_r.output_trigger_enable) && ris_r[`TCP_FLG_TO])
        else $error("trigger without enable or flag");
    a_load_taken: assert property (ilr_wr |=> cnt_r == $past(pwdata[15:0]))
        else $error("counter missed interval write");
    a_freeze_hold: assert property (ctl_r.count_freeze_enable && !ilr_wr |=> $stable(cnt_r))
        else $error("counter moved while frozen");
    a_prescale_wait: assert property (run_w && (mode_w == TCP_ONESHOT || mode_w == TCP_PERIODIC)
                                      && pre_cnt_r != 8'h00 && !ilr_wr
                                      |=> $stable(cnt_r) && pre_cnt_r == $past(pre_cnt_r) - 8'h01)
        else $error("prescaler step wrong");
    a_match_stop: assert property (run_w && mode_w == TCP_ECOUNT && ev_count && cnt_dec == match_r
                                   && !ilr_wr && !(wr_w && hit_ctl) |=> ris_r[`TCP_FLG_MATCH]
                                   && !ctl_r.timer_enable_bit && cnt_r == ilr_r)
        else $error("edge count match handling wrong");
    a_capture_copy: assert property (run_w && mode_w == TCP_ETIME && ev_time && !ilr_wr
                                     |=> cap_r == $past(cnt_r) && ris_r[`TCP_FLG_CAP])
        else $error("capture not taken");
    a_pwm_noflag: assert property (mode_w == TCP_PWM |=> (ris_r & ~$past(ris_r)) == '0)
        else $error("flag raised in pwm mode");
    a_pwm_pin: assert property (run_w && mode_w == TCP_PWM && cnt_r == ilr_r && !ilr_wr
                                |=> ##1 pin_out_r == !$past(ctl_r.pwm_invert_bit))
        else $error("pwm output not active at load");

    c_timeout: cover property (ris_r[`TCP_FLG_TO] && mode_w == TCP_ONESHOT);
    c_match: cover property (ris_r[`TCP_FLG_MATCH] && mode_w == TCP_ECOUNT);
    c_capture: cover property (ris_r[`TCP_FLG_CAP] && mode_w == TCP_ETIME);
    c_pwm_fall: cover property (mode_w == TCP_PWM && $fell(pwm_r));
endmodule

`default_nettype wire

// >>> dv/tcp_pin_model.sv
// Behavioural source on the capture/compare pin, and the resolved pin level.
// Assumes the bench calls toggle() and that pclk is the system clock.
`default_nettype none

module tcp_pin_model (
    input wire logic pclk,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output logic pin_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic src_lvl = 1'b0;

    // ==========================================
    // Pin level: the device wins while its enable is low
    assign pin_in = pin_oe_n ? src_lvl : pin_out;

    // ==========================================
    // Edge source
    // hold each level
    task automatic toggle(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge pclk);
            src_lvl <= ~src_lvl;
        end
        repeat (8) @(posedge pclk); // Let synchroniser and counter settle
    endtask
endmodule

`default_nettype wire

// >>> dv/tcp_timer16_tb.sv
// Self-checking bench for the 16-bit timer half, driven over APB.
// Assumes the design files and the pin model are compiled first.
`default_nettype none
`include "tcp_defs.svh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected %s: expected %h seen %h", nm, exp, got); end end

module tcp_timer16_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, timeout_trigger, pin_in, pin_out, pin_oe_n, last_err;
    logic [31:0] q, tv1;
    int error_cnt = 0;
    int n_compared = 0;
    int trig_cnt = 0;
    int h, t0, tp;
    logic [7:0] pre_t [3] = '{8'h00, 8'h03, 8'hFF};
    logic [5:0] ec_ctl [3] = '{6'h01, 6'h05, 6'h0D};
    int ec_n [3] = '{3, 3, 6};

    // ==========================================
    // Clock, trigger counter, design and pin model
    always #10 pclk = ~pclk;
    always @(posedge pclk) if (timeout_trigger === 1'b1) trig_cnt <= trig_cnt + 1;

    tcp_timer16 dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .timeout_trigger(timeout_trigger), .capture_compare_pin_in(pin_in), .capture_compare_pin_out(pin_out),
        .capture_compare_pin_oe_n(pin_oe_n));
    tcp_pin_model src_u (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

    // ==========================================
    // Bus tasks
    // One APB transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, q)
    endtask

    // Cycles until the interrupt line rises, bounded only by the watchdog
    task automatic wait_irq(output int c);
        c = 0;
        while (irq !== 1'b1)
        begin
            @(posedge pclk);
            c++;
        end
    endtask

    // High cycles of the pin output over two PWM periods
    task automatic hi_count(output int hc);
        hc = 0;
        repeat (20)
        begin
            @(posedge pclk);
            if (pin_out === 1'b1) hc++;
        end
    endtask

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================
    // Watchdog
    initial
    begin
        repeat (40000) @(posedge pclk);
        error_cnt++;
        stop_test();
    end

    // ==========================================
    // Test sequence
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ilr", `TCP_OFS_ILR, 32'h0000_FFFF);
        rdc("tv", `TCP_OFS_TV, 32'h0000_FFFF);
        rdc("pr", `TCP_OFS_PR, 32'h0000_0000);
        rdc("unmapped", 12'h0FC, 32'h0000_0000);
        `CHK("slverr", 1'b1, last_err)
        // Nothing counts before 16-bit configuration
        wr(`TCP_OFS_MODE, 32'h2);
        wr(`TCP_OFS_ILR, 32'h5);
        wr(`TCP_OFS_CTL, 32'h1);
        repeat (20) @(posedge pclk);
        rdc("tv", `TCP_OFS_TV, 32'h5);
        // Periodic timeout, flags, trigger and clear
        wr(`TCP_OFS_CFG, 32'h4);
        wr(`TCP_OFS_IMR, 32'h1);
        wr(`TCP_OFS_ILR, 32'h2);
        wr(`TCP_OFS_CTL, 32'h11);
        wait_irq(h);
        rdc("ris", `TCP_OFS_RIS, 32'h1);
        rdc("mis", `TCP_OFS_MIS, 32'h1);
        t0 = trig_cnt;
        repeat (30) @(posedge pclk);
        `CHK("trigger", 1'b1, trig_cnt - t0 > 8)
        wr(`TCP_OFS_CTL, 32'h1);
        // Let a pulse launched before the disable be counted first
        repeat (2) @(posedge pclk);
        t0 = trig_cnt;
        repeat (30) @(posedge pclk);
        `CHK("trigger", t0, trig_cnt)
        wr(`TCP_OFS_CTL, 32'h0);
        wr(`TCP_OFS_ICR, 32'h0);
        rdc("ris", `TCP_OFS_RIS, 32'h1);
        wr(`TCP_OFS_ICR, 32'h1);
        rdc("ris", `TCP_OFS_RIS, 32'h0);
        `CHK("irq", 1'b0, irq)
        // Reload while running, then freeze and resume
        wr(`TCP_OFS_ILR, 32'hFFFF);
        wr(`TCP_OFS_CTL, 32'h1);
        repeat (10) @(posedge pclk);
        wr(`TCP_OFS_ILR, 32'h40);
        apb(1'b0, `TCP_OFS_TV, 32'h0);
        `CHK("reload", 1'b1, q[15:0] <= 16'h0040 && q[15:0] > 16'h0038)
        wr(`TCP_OFS_CTL, 32'h3);
        apb(1'b0, `TCP_OFS_TV, 32'h0);
        tv1 = q;
        repeat (10) @(posedge pclk);
        rdc("frozen", `TCP_OFS_TV, tv1);
        wr(`TCP_OFS_CTL, 32'h1);
        apb(1'b0, `TCP_OFS_TV, 32'h0);
        `CHK("resumed", 1'b1, q !== tv1)
        wr(`TCP_OFS_CTL, 32'h0);
        wr(`TCP_OFS_ICR, 32'h7);
        // One-shot: interval 3 against interval 1, per prescale
        wr(`TCP_OFS_MODE, 32'h1);
        for (int i = 0; i < 3; i++)
            for (int j = 0; j < 3; j++)
            begin
                wr(`TCP_OFS_PR, {24'h0, pre_t[i]});
                wr(`TCP_OFS_ILR, (j == 2) ? 32'h3 : 32'h1);
                wr(`TCP_OFS_CTL, 32'h1);
                wait_irq(tp);
                if (j == 1) t0 = tp;
                if (j == 2) `CHK("prescale", 2 * (int'(pre_t[i]) + 1), tp - t0)
                rdc("stopped", `TCP_OFS_CTL, 32'h0);
                wr(`TCP_OFS_ICR, 32'h1);
            end
        rdc("tv", `TCP_OFS_TV, 32'h3);
        // Edge counting for each edge selection
        wr(`TCP_OFS_MODE, 32'h3);
        wr(`TCP_OFS_MATCH, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr(`TCP_OFS_ILR, 32'hA);
            wr(`TCP_OFS_CTL, {26'h0, ec_ctl[i]});
            src_u.toggle(6);
            rdc("edges", `TCP_OFS_TV, 32'hA - ec_n[i]);
            wr(`TCP_OFS_CTL, 32'h0);
        end
        // Edge count match stops the counter
        wr(`TCP_OFS_MATCH, 32'h6);
        wr(`TCP_OFS_IMR, 32'h2);
        wr(`TCP_OFS_ILR, 32'hA);
        wr(`TCP_OFS_CTL, 32'hD);
        src_u.toggle(6);
        rdc("tv", `TCP_OFS_TV, 32'hA);
        rdc("ctl", `TCP_OFS_CTL, 32'hC);
        rdc("ris", `TCP_OFS_RIS, 32'h2);
        rdc("mis", `TCP_OFS_MIS, 32'h2);
        wr(`TCP_OFS_ICR, 32'h7);
        // Edge time capture and hold
        wr(`TCP_OFS_MODE, 32'h7);
        wr(`TCP_OFS_IMR, 32'h4);
        wr(`TCP_OFS_ILR, 32'hFFFF);
        wr(`TCP_OFS_CTL, 32'h1);
        src_u.toggle(1);
        apb(1'b0, `TCP_OFS_TV, 32'h0);
        tv1 = q;
        repeat (20) @(posedge pclk);
        rdc("held", `TCP_OFS_TV, tv1);
        rdc("ris", `TCP_OFS_RIS, 32'h4);
        `CHK("irq", 1'b1, irq)
        src_u.toggle(2);
        apb(1'b0, `TCP_OFS_TV, 32'h0);
        `CHK("recapture", 1'b1, q < tv1)
        wr(`TCP_OFS_CTL, 32'h0);
        wr(`TCP_OFS_ICR, 32'h7);
        // PWM duty, inversion and no flags; prescale left at its maximum
        wr(`TCP_OFS_MODE, 32'hA);
        wr(`TCP_OFS_ILR, 32'h9);
        wr(`TCP_OFS_MATCH, 32'h3);
        wr(`TCP_OFS_CTL, 32'h1);
        repeat (4) @(posedge pclk);
        hi_count(h);
        `CHK("pwm high", 12, h)
        `CHK("pwm drive", 1'b0, pin_oe_n)
        wr(`TCP_OFS_CTL, 32'h21);
        repeat (4) @(posedge pclk);
        hi_count(h);
        `CHK("pwm inverted", 8, h)
        rdc("ris", `TCP_OFS_RIS, 32'h0);
        wr(`TCP_OFS_MODE, 32'h2);
        repeat (2) @(posedge pclk);
        `CHK("no pwm", 1'b1, pin_oe_n)
        stop_test();
    end
endmodule

`default_nettype wire
